// file: pkg/idm_pkg.sv
// Package for the data-memory address generator.
// Assumes a single core clock; sector and offset widths as listed here.
package idm_pkg;
   // Special-function offsets in sector 0
   localparam logic [7:0] IDM_OFF_PORT0   = 8'h00;
   localparam logic [7:0] IDM_OFF_PTR0    = 8'h01;
   localparam logic [7:0] IDM_OFF_PORT1   = 8'h02;
   localparam logic [7:0] IDM_OFF_PTR1LO  = 8'h03;
   localparam logic [7:0] IDM_OFF_PTR1SEC = 8'h04;
   localparam logic [7:0] IDM_OFF_PORT2   = 8'h0c;
   localparam logic [7:0] IDM_OFF_PTR2LO  = 8'h0d;
   localparam logic [7:0] IDM_OFF_PTR2SEC = 8'h0e;
   // Special-function space ends below this offset
   localparam logic [7:0] IDM_SFR_END     = 8'h80;
   localparam logic [7:0] IDM_ZERO_BYTE   = 8'h00;
   localparam logic [7:0] IDM_PTR_RESET   = 8'h00;
   localparam int         IDM_ADDR_W_SMALL = 9;
   localparam int         IDM_ADDR_W_LARGE = 11;

   // Core access request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        ext;
      logic [10:0] addr;
      logic [7:0]  wdata;
   } idm_req_t;

   // Memory-side access
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [2:0]  sector;
      logic [7:0]  offset;
      logic [7:0]  wdata;
   } idm_mem_t;

   typedef enum logic [1:0] {
      IDM_SRC_DIRECT,
      IDM_SRC_PORT0,
      IDM_SRC_PORT1,
      IDM_SRC_PORT2
   } idm_src_t;
endpackage

// file: verilog/idm_addr_gen.sv
// Data-memory address generator: indirect ports, pointers, sector+offset.
// Assumes the core presents one access per cycle and returns read data
// from the memory in the same cycle; reserved map comes in as a mask.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Contract
// - Port access is redirected to the address held by its pointer.
// - Ports read as their own registers return 00H.
// - Writes to a port location never change that location.
// - Port zero with single pointer reaches sector 0 only.
// - Ports one and two: pointer high byte is sector, low byte offset.
// - Five pointer bytes are stored registers, readable and writable.
// - Direct extended addressing reaches every sector.
// - Extended direct address upper part selects sector, low byte offset.
// - Reserved special-function locations ignore writes.
// - Extended address carries 9 or 11 valid bits per variant.
// - Unused special-function locations read as 00H.
module idm_addr_gen #(
   parameter int ADDR_W = idm_pkg::IDM_ADDR_W_LARGE
) (
   input  wire logic             CLK_I,
   input  wire logic             RST_I,
   input  wire idm_pkg::idm_req_t REQ_I,
   input  wire logic             UNUSED_I,
   input  wire logic             RESERVED_I,
   output idm_pkg::idm_mem_t     MEM_O,
   input  wire logic [7:0]       MEM_RDATA_I,
   output logic [7:0]            RDATA_O
);
   localparam int SEC_W = ADDR_W - 8;

   ////////////////////////////////////////////////////////////////////////
   // Pointer storage
   logic [7:0] ptr0_r;
   logic [7:0] ptr1lo_r;
   logic [7:0] ptr1sec_r;
   logic [7:0] ptr2lo_r;
   logic [7:0] ptr2sec_r;

   // Address masked to the variant width
   wire [10:0] addr_m = REQ_I.addr & 11'((1 << ADDR_W) - 1);
   wire [2:0]  dsec   = REQ_I.ext ? 3'(addr_m[10:8]) : 3'h0;
   wire [7:0]  doff   = addr_m[7:0];
   wire        in_s0  = (dsec == 3'h0);

   // Direct-target decode
   wire hit_p0  = in_s0 && (doff == idm_pkg::IDM_OFF_PORT0);
   wire hit_p1  = in_s0 && (doff == idm_pkg::IDM_OFF_PORT1);
   wire hit_p2  = in_s0 && (doff == idm_pkg::IDM_OFF_PORT2);
   wire hit_m0  = in_s0 && (doff == idm_pkg::IDM_OFF_PTR0);
   wire hit_m1l = in_s0 && (doff == idm_pkg::IDM_OFF_PTR1LO);
   wire hit_m1h = in_s0 && (doff == idm_pkg::IDM_OFF_PTR1SEC);
   wire hit_m2l = in_s0 && (doff == idm_pkg::IDM_OFF_PTR2LO);
   wire hit_m2h = in_s0 && (doff == idm_pkg::IDM_OFF_PTR2SEC);
   wire hit_ptr = hit_m0 | hit_m1l | hit_m1h | hit_m2l | hit_m2h;

   // Source selection
   idm_pkg::idm_src_t src;
   assign src = hit_p0 ? idm_pkg::IDM_SRC_PORT0 :
                hit_p1 ? idm_pkg::IDM_SRC_PORT1 :
                hit_p2 ? idm_pkg::IDM_SRC_PORT2 : idm_pkg::IDM_SRC_DIRECT;

   // Effective address from current pointers
   logic [2:0] eff_sec;
   logic [7:0] eff_off;
   always_comb begin
      case (src)
         idm_pkg::IDM_SRC_PORT0: begin
            eff_sec = 3'h0;
            eff_off = ptr0_r;
         end
         idm_pkg::IDM_SRC_PORT1: begin
            eff_sec = 3'(ptr1sec_r[SEC_W-1:0]);
            eff_off = ptr1lo_r;
         end
         idm_pkg::IDM_SRC_PORT2: begin
            eff_sec = 3'(ptr2sec_r[SEC_W-1:0]);
            eff_off = ptr2lo_r;
         end
         default: begin
            eff_sec = dsec;
            eff_off = doff;
         end
      endcase
   end

   // Port whose pointer points back at a port location lands nowhere
   wire eff_s0   = (eff_sec == 3'h0);
   wire eff_port = eff_s0 && ((eff_off == idm_pkg::IDM_OFF_PORT0) ||
                   (eff_off == idm_pkg::IDM_OFF_PORT1) ||
                   (eff_off == idm_pkg::IDM_OFF_PORT2));
   wire eff_ptr  = eff_s0 && ((eff_off == idm_pkg::IDM_OFF_PTR0) ||
                   (eff_off == idm_pkg::IDM_OFF_PTR1LO) ||
                   (eff_off == idm_pkg::IDM_OFF_PTR1SEC) ||
                   (eff_off == idm_pkg::IDM_OFF_PTR2LO) ||
                   (eff_off == idm_pkg::IDM_OFF_PTR2SEC));
   wire eff_sfr  = eff_s0 && (eff_off < idm_pkg::IDM_SFR_END);
   // Reserved/unused flags describe the effective location
   wire wr_ok    = REQ_I.wr && !eff_port && !(eff_sfr && RESERVED_I);
   wire ptr_wr   = wr_ok && eff_ptr;

   ////////////////////////////////////////////////////////////////////////
   // Pointer register writes
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         ptr0_r    <= idm_pkg::IDM_PTR_RESET;
         ptr1lo_r  <= idm_pkg::IDM_PTR_RESET;
         ptr1sec_r <= idm_pkg::IDM_PTR_RESET;
         ptr2lo_r  <= idm_pkg::IDM_PTR_RESET;
         ptr2sec_r <= idm_pkg::IDM_PTR_RESET;
      end else if (ptr_wr) begin
         if (eff_off == idm_pkg::IDM_OFF_PTR0)    ptr0_r    <= REQ_I.wdata;
         if (eff_off == idm_pkg::IDM_OFF_PTR1LO)  ptr1lo_r  <= REQ_I.wdata;
         if (eff_off == idm_pkg::IDM_OFF_PTR1SEC) ptr1sec_r <= REQ_I.wdata;
         if (eff_off == idm_pkg::IDM_OFF_PTR2LO)  ptr2lo_r  <= REQ_I.wdata;
         if (eff_off == idm_pkg::IDM_OFF_PTR2SEC) ptr2sec_r <= REQ_I.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Memory-side request, combinational
   assign MEM_O.rd     = REQ_I.rd && !eff_port && !eff_ptr;
   assign MEM_O.wr     = wr_ok && !eff_ptr;
   assign MEM_O.sector = eff_sec;
   assign MEM_O.offset = eff_off;
   assign MEM_O.wdata  = REQ_I.wdata;

   // Read data selection
   logic [7:0] ptr_rd;
   always_comb begin
      if (eff_off == idm_pkg::IDM_OFF_PTR0)         ptr_rd = ptr0_r;
      else if (eff_off == idm_pkg::IDM_OFF_PTR1LO)  ptr_rd = ptr1lo_r;
      else if (eff_off == idm_pkg::IDM_OFF_PTR1SEC) ptr_rd = ptr1sec_r;
      else if (eff_off == idm_pkg::IDM_OFF_PTR2LO)  ptr_rd = ptr2lo_r;
      else                                          ptr_rd = ptr2sec_r;
   end
   assign RDATA_O = !REQ_I.rd              ? idm_pkg::IDM_ZERO_BYTE :
                    eff_port               ? idm_pkg::IDM_ZERO_BYTE :
                    eff_ptr                ? ptr_rd :
                    (eff_sfr && UNUSED_I)  ? idm_pkg::IDM_ZERO_BYTE :
                    MEM_RDATA_I;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   // Port zero never leaves sector 0
   port0_sector_a: assert property (
      hit_p0 |-> eff_sec == 3'h0 && eff_off == ptr0_r)
      else $error("port zero not redirected into sector 0");

   // Port one takes sector and offset from its pointer pair
   port1_route_a: assert property (
      hit_p1 |-> eff_off == ptr1lo_r && eff_sec == 3'(ptr1sec_r[SEC_W-1:0]))
      else $error("port one address wrong");

   // Port two takes sector and offset from its pointer pair
   port2_route_a: assert property (
      hit_p2 |-> eff_off == ptr2lo_r && eff_sec == 3'(ptr2sec_r[SEC_W-1:0]))
      else $error("port two address wrong");

   // A port location read as itself gives zero
   port_read_zero_a: assert property (
      REQ_I.rd && eff_port |-> RDATA_O == idm_pkg::IDM_ZERO_BYTE)
      else $error("port location read not zero");

   // A port location is never stored into
   port_no_write_a: assert property (
      eff_port |-> !MEM_O.wr && !ptr_wr)
      else $error("port location written");

   // A port location never reaches the RAM for reading either
   port_no_read_a: assert property (
      eff_port |-> !MEM_O.rd)
      else $error("port location read from RAM");

   // Reserved special-function places keep their contents
   reserved_hold_a: assert property (
      REQ_I.wr && eff_sfr && RESERVED_I |-> !MEM_O.wr && !ptr_wr)
      else $error("reserved location written");

   // Extended direct address splits into sector and offset
   direct_split_a: assert property (
      REQ_I.ext && src == idm_pkg::IDM_SRC_DIRECT |->
      MEM_O.sector == 3'(addr_m[10:8]) && MEM_O.offset == addr_m[7:0])
      else $error("extended address split wrong");

   // Plain direct access stays in sector 0
   plain_sector_a: assert property (
      !REQ_I.ext && src == idm_pkg::IDM_SRC_DIRECT |-> MEM_O.sector == 3'h0)
      else $error("plain direct access left sector 0");

   // Sector bits beyond the variant width stay clear
   sector_width_a: assert property (
      REQ_I.ext |-> (MEM_O.sector >> SEC_W) == 3'h0)
      else $error("sector wider than variant");

   // A write to pointer zero lands in ptr0_r
   ptr_store_a: assert property (
      ptr_wr && eff_off == idm_pkg::IDM_OFF_PTR0 |=> ptr0_r == $past(REQ_I.wdata))
      else $error("pointer zero not stored");

   // Pointers are never sent to the RAM
   ptr_local_a: assert property (
      eff_ptr |-> !MEM_O.wr && !MEM_O.rd)
      else $error("pointer access leaked to RAM");

   // Pointers hold when nothing writes them
   ptr_hold_a: assert property (
      !ptr_wr |=> $stable(ptr0_r) && $stable(ptr1lo_r) && $stable(ptr1sec_r) &&
      $stable(ptr2lo_r) && $stable(ptr2sec_r))
      else $error("pointer changed without write");

   // Pointer zero written in one cycle steers port zero in the next
   ptr_immediate_a: assert property (
      ptr_wr && eff_off == idm_pkg::IDM_OFF_PTR0 ##1 hit_p0 |->
      MEM_O.offset == $past(REQ_I.wdata))
      else $error("updated pointer not used at once");

   // Unused special-function places read as zero
   unused_zero_a: assert property (
      REQ_I.rd && eff_sfr && UNUSED_I && !eff_ptr |-> RDATA_O == idm_pkg::IDM_ZERO_BYTE)
      else $error("unused location read not zero");

   // Write data goes to the RAM unchanged
   wdata_pass_a: assert property (
      MEM_O.wr |-> MEM_O.wdata == REQ_I.wdata)
      else $error("write data altered");

   // Main scenarios
   port1_cov_c:   cover property (hit_p1 && REQ_I.wr && eff_sec != 3'h0);
   port0_cov_c:   cover property (hit_p0 && REQ_I.rd);
   ext_cov_c:     cover property (REQ_I.ext && REQ_I.rd && dsec != 3'h0);
   ptr_then_c:    cover property (ptr_wr ##1 hit_p2);
endmodule

// file: sim/idm_ram_model.sv
// Behavioural data RAM on the memory side of the address generator.
// Assumes writes land on the core clock edge and reads answer in the same cycle.
`timescale 1ns/1ps
module idm_ram_model (
   input  wire logic              clk_i,
   input  wire idm_pkg::idm_mem_t mem_i,
   output logic [7:0]             rdata_o
);
   logic [7:0] ram [0:2047];
   logic [7:0] last_r = 8'h00;
   // Store on the edge; remember the last byte for the idle pattern
   always_ff @(posedge clk_i) begin
      if (mem_i.wr) begin
         ram[{mem_i.sector, mem_i.offset}] <= mem_i.wdata;
      end
      last_r <= rdata_o;
   end
   // Idle data lines toggle so that a stale byte never looks valid
   assign rdata_o = mem_i.rd ? ram[{mem_i.sector, mem_i.offset}] : ~last_r;
endmodule

// file: sim/tb_idm_addr_gen.sv
// Self-checking bench for the data-memory address generator.
// Assumes the RAM model answers reads in the same cycle.
`timescale 1ns/1ps
module tb_idm_addr_gen;
   logic              CLK_I = 1'b0;
   logic              RST_I = 1'b1;
   logic              UNUSED_I = 1'b0;
   logic              RESERVED_I = 1'b0;
   idm_pkg::idm_req_t REQ_I = '0;
   idm_pkg::idm_mem_t MEM_O;
   logic [7:0]        MEM_RDATA_I;
   logic [7:0]        RDATA_O;
   int                fail_count = 0;
   int                checks = 0;

   idm_addr_gen i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .REQ_I(REQ_I), .UNUSED_I(UNUSED_I),
      .RESERVED_I(RESERVED_I), .MEM_O(MEM_O), .MEM_RDATA_I(MEM_RDATA_I), .RDATA_O(RDATA_O));
   idm_ram_model i_ram (.clk_i(CLK_I), .mem_i(MEM_O), .rdata_o(MEM_RDATA_I));

   // 50 MHz core clock
   initial begin
      forever #10 CLK_I = ~CLK_I;
   end

   // One access per cycle, driven just after the edge, looked at mid-cycle
   task automatic acc(input logic r, w, e, input logic [10:0] a, input logic [7:0] d,
                      input logic u = 1'b0, input logic rv = 1'b0);
      @(posedge CLK_I);
      #1;
      REQ_I = '{rd: r, wr: w, ext: e, addr: a, wdata: d};
      UNUSED_I = u;
      RESERVED_I = rv;
      #8;
   endtask

   task automatic chk(input logic [18:0] got, input logic [18:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Port zero follows its single-byte pointer inside sector 0
   task automatic t_port0();
      acc(1'b0, 1'b1, 1'b0, 11'h001, 8'h40);
      acc(1'b0, 1'b1, 1'b0, 11'h000, 8'h5a);
      chk({MEM_O.wr, MEM_O.sector, MEM_O.offset}, {1'b1, 3'h0, 8'h40});
      chk(MEM_O.wdata, 8'h5a);
      acc(1'b1, 1'b0, 1'b0, 11'h001, 8'h00);
      chk(RDATA_O, 8'h40);
      acc(1'b1, 1'b0, 1'b0, 11'h040, 8'h00);
      chk(MEM_O.rd, 1'b1);
      chk(RDATA_O, 8'h5a);
   endtask

   // Reset in mid-run clears the port-two sector pointer again
   task automatic t_reset();
      acc(1'b0, 1'b1, 1'b0, 11'h00e, 8'h06);
      @(posedge CLK_I);
      #1;
      REQ_I = '0;
      RST_I = 1'b1;
      @(posedge CLK_I);
      #1;
      RST_I = 1'b0;
      acc(1'b1, 1'b0, 1'b0, 11'h00e, 8'h00);
      chk(RDATA_O, 8'h00);
      chk(MEM_O.rd, 1'b0);
   endtask

   // Ports one and two take sector and offset from their pointer pairs
   task automatic t_ports12();
      logic [7:0] port_a;
      logic [7:0] sec;
      for (int i = 0; i < 2; i++) begin
         port_a = (i == 0) ? 8'h02 : 8'h0c;
         sec = 8'h02 + 8'(3 * i);
         acc(1'b0, 1'b1, 1'b0, {3'h0, port_a + 8'h02}, sec);
         acc(1'b0, 1'b1, 1'b0, {3'h0, port_a + 8'h01}, 8'h33);
         acc(1'b0, 1'b1, 1'b0, {3'h0, port_a}, 8'ha0 + 8'(i));
         chk({MEM_O.wr, MEM_O.sector, MEM_O.offset}, {1'b1, sec[2:0], 8'h33});
         acc(1'b1, 1'b0, 1'b1, {sec[2:0], 8'h33}, 8'h00);
         chk(RDATA_O, 8'ha0 + 8'(i));
      end
      acc(1'b0, 1'b1, 1'b1, 11'h1f0, 8'h3c);
      chk({MEM_O.wr, MEM_O.sector, MEM_O.offset}, {1'b1, 3'h1, 8'hf0});
   endtask

   // Port aimed at a port location, then unused and reserved places
   task automatic t_special();
      acc(1'b0, 1'b1, 1'b0, 11'h001, 8'h02);
      acc(1'b1, 1'b0, 1'b0, 11'h000, 8'h00);
      chk(RDATA_O, 8'h00);
      acc(1'b0, 1'b1, 1'b0, 11'h000, 8'h77);
      chk(MEM_O.wr, 1'b0);
      acc(1'b1, 1'b0, 1'b0, 11'h00b, 8'h00, 1'b1);
      chk(RDATA_O, 8'h00);
      acc(1'b0, 1'b1, 1'b0, 11'h03e, 8'h11, 1'b0, 1'b1);
      chk(MEM_O.wr, 1'b0);
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Reset, then the scenarios in turn
   initial begin
      repeat (12) @(posedge CLK_I);
      #1;
      RST_I = 1'b0;
      t_port0();
      t_ports12();
      t_special();
      t_reset();
      acc(1'b0, 1'b0, 1'b0, 11'h000, 8'h00);
      wrap_up();
   end

   // Cut a hang short
   initial begin
      #100000;
      fail_count++;
      wrap_up();
   end
endmodule
